/* rtl/lics_pkg.sv */
// Package for the charge-cycle sequencer: states and timing counts
package lics_pkg;

    localparam longint CLK_HZ         = 64'd250000000;
    localparam longint PRE_TIME_MIN   = 64'd30;
    localparam longint FAST_TIME_HR   = 64'd10;
    localparam longint BOOST_TIME_MIN = 64'd1;
    localparam longint DET_TIME_US    = 64'd100;

    // Cycle counts derived from the times at the clock rate
    localparam longint PRE_CYC   = PRE_TIME_MIN * 64'd60 * CLK_HZ;
    localparam longint FAST_CYC  = FAST_TIME_HR * 64'd3600 * CLK_HZ;
    localparam longint BOOST_CYC = BOOST_TIME_MIN * 64'd60 * CLK_HZ;
    localparam longint DET_CYC   = (DET_TIME_US * CLK_HZ) / 64'd1000000;

    localparam int TMR_W = 44;
    localparam int SYNC_W = 9;

    // Flag positions in the synchroniser vector
    localparam int F_TAPER  = 0;
    localparam int F_ABOVE  = 1;
    localparam int F_HIGH   = 2;
    localparam int F_LOW    = 3;
    localparam int F_TFAULT = 4;
    localparam int F_THREG  = 5;
    localparam int F_DPM    = 6;
    localparam int F_ILIM   = 7;
    localparam int F_BATOK  = 8;

    typedef enum logic [2:0] {
        LICS_IDLE  = 3'b000,
        LICS_DET   = 3'b001,
        LICS_PRE   = 3'b010,
        LICS_FAST  = 3'b011,
        LICS_DONE  = 3'b100,
        LICS_FAULT = 3'b101,
        LICS_DIS   = 3'b110
    } lics_state_e;

endpackage

/* rtl/lics_sync_if.sv */
// Interface carrying raw and synchronised comparator flags
`timescale 1ns/100ps
interface lics_sync_if;
    import lics_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] flg;
    modport src (output raw, input flg);
    modport snk (input raw, output flg);
endinterface

/* rtl/lics_sync.sv */
// Two-stage synchroniser for the analog comparator flags
`timescale 1ns/100ps
module lics_sync (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    lics_sync_if.snk  sif
);
    import lics_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } lics_sync_s;

    lics_sync_s st_r;
    lics_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Preload both stages so the first edge after reset sees real flags
            st_r <= {sif.raw, sif.raw};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.flg = st_r.s2;
endmodule

/* rtl/lics_seq.sv */
// Charge-cycle sequencer: disable mode, safety timers, termination, detection
// Operation
// - Thermistor input high enters disable mode
// - Disable mode holds timer reset, no termination
// - Entry detection; no battery releases status
// - Battery present: release status on taper
// - Disable mode keeps full charge profile
// - Exit detection; battery starts cycle, status active
// - Pre-charge limited to thirty minutes
// - Fast timer ten hours, half rate when limited
// - Timer expiry terminates, releases status
// - Timers cleared on disable, power, mode cycle
// - Above threshold and tapered: release, detect
// - Battery present after termination stops current
// - Missing battery, active thermistor: repeat detection
// - Status released when detection finds battery missing
// - Detect on mode entry, exit, missing battery
// - Power-up above recharge threshold runs detection
// - Single detection in disable mode; fault ends it outside disable mode
// - Below recharge after termination restarts, status off
// - Termination threshold raised first minute
// - Thermistor low disables; release starts first charge
`timescale 1ns/100ps
module lics_seq (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    // Analog comparator flags, raw
    input  wire logic taper_i,
    input  wire logic above_rch_i,
    input  wire logic ts_high_i,
    input  wire logic ts_low_i,
    input  wire logic ts_fault_i,
    input  wire logic thermal_reg_i,
    input  wire logic input_voltage_power_management_i,
    input  wire logic usb_ilim_i,
    input  wire logic bat_present_i,
    // Control outputs to the power stage
    output logic      charge_en_o,
    output logic      precharge_o,
    output logic      detect_o,
    output logic      term_boost_o,
    output logic      disable_mode_o,
    output lics_pkg::lics_state_e state_o,
    // Open-drain status pin
    output logic      chg_status_o,
    output logic      chg_status_oe_o
);
    import lics_pkg::*;

    localparam logic [TMR_W-1:0] PRE_LIM   = TMR_W'(PRE_CYC);
    localparam logic [TMR_W-1:0] FAST_LIM  = TMR_W'(FAST_CYC);
    localparam logic [TMR_W-1:0] BOOST_LIM = TMR_W'(BOOST_CYC);
    localparam logic [TMR_W-1:0] DET_LIM   = TMR_W'(DET_CYC);

    typedef struct packed {
        lics_state_e      st;
        logic [TMR_W-1:0] tmr;     // Safety timer
        logic [TMR_W-1:0] boost;   // First-minute counter
        logic [TMR_W-1:0] det;     // Detection window
        logic             half;    // Half-rate prescale
        logic             termination_timer_disable_mode;
        logic             first;   // First charge in progress
        logic             stat_on; // Status pin pulled low
        logic             det_exit;
        logic             pwrup;
    } lics_seq_s;

    lics_seq_s st_r;
    lics_seq_s st_nxt;

    lics_sync_if sif ();
    logic [SYNC_W-1:0] f;

    assign sif.raw = {bat_present_i, usb_ilim_i, input_voltage_power_management_i, thermal_reg_i,
                      ts_fault_i, ts_low_i, ts_high_i, above_rch_i, taper_i};
    assign f = sif.flg;

    lics_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .sif       (sif)
    );

    logic slow;
    logic det_done;
    logic tmr_tick;

    always_comb begin
        slow     = f[F_THREG] | f[F_DPM] | f[F_ILIM];
        det_done = (st_r.det >= DET_LIM - TMR_W'(1));
        tmr_tick = !slow | st_r.half;
        st_nxt   = st_r;
        st_nxt.pwrup = 1'b0;

        if (st_r.boost != BOOST_LIM) begin
            st_nxt.boost = st_r.boost + TMR_W'(1);
        end

        if (f[F_LOW]) begin
            // Charge disabled; release counts as a fresh first charge
            st_nxt.st      = LICS_IDLE;
            st_nxt.tmr     = '0;
            st_nxt.stat_on = 1'b0;
            st_nxt.first   = 1'b1;
            st_nxt.termination_timer_disable_mode    = 1'b0;
        end else if (f[F_HIGH] && !st_r.termination_timer_disable_mode) begin
            st_nxt.termination_timer_disable_mode = 1'b1;
            st_nxt.tmr  = '0;
            st_nxt.st   = LICS_DET;
            st_nxt.det  = '0;
            st_nxt.det_exit = 1'b0;
        end else if (!f[F_HIGH] && st_r.termination_timer_disable_mode) begin
            st_nxt.termination_timer_disable_mode = 1'b0;
            st_nxt.tmr  = '0;
            st_nxt.st   = LICS_DET;
            st_nxt.det  = '0;
            st_nxt.det_exit = 1'b1;
        end else begin
            case (st_r.st)
                LICS_IDLE: begin
                    // Released from disable or power-up
                    st_nxt.st  = LICS_DET;
                    st_nxt.det = '0;
                    st_nxt.det_exit = 1'b1;
                    // Low battery at power-up or after a disable release charges at once
                    if ((st_r.pwrup || st_r.first) && !f[F_ABOVE]) begin
                        st_nxt.st    = LICS_PRE;
                        st_nxt.boost = '0;
                        st_nxt.stat_on = 1'b1;
                    end
                end
                LICS_DET: begin
                    if (f[F_TFAULT] && !st_r.termination_timer_disable_mode) begin
                        st_nxt.st = LICS_FAULT;
                    end else if (st_r.termination_timer_disable_mode) begin
                        // Single check on entry to disable mode
                        st_nxt.det = st_r.det + TMR_W'(1);
                        if (det_done) begin
                            if (!f[F_BATOK]) begin
                                st_nxt.stat_on = 1'b0;
                            end
                            st_nxt.st = LICS_PRE;
                        end
                    end else begin
                        st_nxt.det = st_r.det + TMR_W'(1);
                        if (det_done) begin
                            st_nxt.det = '0;
                            if (f[F_BATOK]) begin
                                if (st_r.det_exit) begin
                                    st_nxt.st      = LICS_PRE;
                                    st_nxt.tmr     = '0;
                                    st_nxt.boost   = '0;
                                    st_nxt.stat_on = 1'b1;
                                end else begin
                                    st_nxt.st = LICS_DONE;
                                end
                            end else begin
                                st_nxt.stat_on  = 1'b0;
                                st_nxt.det_exit = 1'b1;
                            end
                        end
                    end
                end
                LICS_PRE, LICS_FAST: begin
                    if (f[F_TFAULT]) begin
                        st_nxt.st = LICS_FAULT;
                    end else if (st_r.termination_timer_disable_mode) begin
                        st_nxt.tmr = '0;
                        if (f[F_ABOVE] && f[F_TAPER]) begin
                            st_nxt.stat_on = 1'b0;
                        end
                        if (st_r.st == LICS_PRE && f[F_ABOVE]) begin
                            st_nxt.st = LICS_FAST;
                        end
                    end else begin
                        if (st_r.st == LICS_PRE) begin
                            st_nxt.tmr = st_r.tmr + TMR_W'(1);
                            if (st_r.tmr >= PRE_LIM - TMR_W'(1)) begin
                                st_nxt.st = LICS_DONE;
                                st_nxt.stat_on = 1'b0;
                            end else if (f[F_ABOVE]) begin
                                st_nxt.st  = LICS_FAST;
                                st_nxt.tmr = '0;
                            end
                        end else begin
                            st_nxt.half = slow ? !st_r.half : 1'b0;
                            if (tmr_tick) begin
                                st_nxt.tmr = st_r.tmr + TMR_W'(1);
                            end
                            if (st_r.tmr >= FAST_LIM - TMR_W'(1)) begin
                                st_nxt.st = LICS_DONE;
                                st_nxt.stat_on = 1'b0;
                            end else if (f[F_ABOVE] && f[F_TAPER]) begin
                                st_nxt.stat_on = 1'b0;
                                st_nxt.first   = 1'b0;
                                st_nxt.st      = LICS_DET;
                                st_nxt.det     = '0;
                                st_nxt.det_exit = 1'b0;
                            end
                        end
                    end
                end
                LICS_DONE: begin
                    if (!f[F_ABOVE]) begin
                        // Refresh charge keeps the status released
                        st_nxt.st    = LICS_PRE;
                        st_nxt.tmr   = '0;
                        st_nxt.boost = '0;
                        st_nxt.stat_on = 1'b0;
                    end
                end
                LICS_FAULT: begin
                    if (!f[F_TFAULT]) begin
                        st_nxt.st = LICS_PRE;
                    end
                end
                default: st_nxt.st = LICS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r       <= '0;
            st_r.st    <= LICS_IDLE;
            st_r.first <= 1'b1;
            st_r.pwrup <= 1'b1;
            st_r.boost <= BOOST_LIM;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Current stops after termination, fault and while disabled
    assign charge_en_o    = (st_r.st == LICS_PRE) || (st_r.st == LICS_FAST)
                          || (st_r.st == LICS_DET);
    assign precharge_o    = (st_r.st == LICS_PRE);
    assign detect_o       = (st_r.st == LICS_DET);
    assign term_boost_o   = (st_r.boost != BOOST_LIM) && !st_r.termination_timer_disable_mode;
    assign disable_mode_o = st_r.termination_timer_disable_mode;
    assign state_o        = st_r.st;
    assign chg_status_o    = 1'b0;
    assign chg_status_oe_o = st_r.stat_on;
endmodule

/* verif/lics_seq_assertions.sv */
// Concurrent checks on the charge sequencer ports
`timescale 1ns/100ps
module lics_seq_assertions
    import lics_pkg::*;
(
    // Clock, reset and comparator flags
    input wire logic sys_clk_i, srst_i, taper_i, above_rch_i, ts_high_i, ts_low_i,
    input wire logic ts_fault_i, thermal_reg_i, input_voltage_power_management_i, usb_ilim_i, bat_present_i,
    // Sequencer outputs
    input wire logic charge_en_o, precharge_o, detect_o, term_boost_o, disable_mode_o,
    input wire logic chg_status_o, chg_status_oe_o,
    input wire lics_state_e state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // Four cycles cover the two sync flops plus the state edge
    sequence s_termination_timer_disable_mode_req;
        (ts_high_i && !ts_low_i && !ts_fault_i) [*4];
    endsequence
    sequence s_fault_held;
        ts_fault_i [*4];
    endsequence
    sequence s_det_to_pre;
        (state_o == LICS_DET && !disable_mode_o) ##1 (state_o == LICS_PRE);
    endsequence

    termination_timer_disable_mode_entry_a: assert property (s_termination_timer_disable_mode_req |=> disable_mode_o)
        else $error("disable mode not entered on high thermistor input");
    dis_no_done_a: assert property (disable_mode_o |-> state_o != LICS_DONE)
        else $error("termination reached in disable mode");
    det_entry_a: assert property ($rose(disable_mode_o) |-> ##[0:1] detect_o)
        else $error("no detection on disable mode entry");
    det_exit_a: assert property ($fell(disable_mode_o) |-> ##[0:1] detect_o)
        else $error("no detection on disable mode exit");
    new_cycle_a: assert property (s_det_to_pre |-> chg_status_oe_o)
        else $error("status not active after detection found a battery");
    no_det_fault_a: assert property (s_fault_held |=> !detect_o)
        else $error("detection ran during a thermistor fault");
    ts_low_off_a: assert property (ts_low_i [*4] |=> !charge_en_o)
        else $error("charge on while thermistor input held low");
    boost_dis_a: assert property (disable_mode_o |-> !term_boost_o)
        else $error("termination boost active in disable mode");
    open_drain_a: assert property (chg_status_oe_o |-> chg_status_o == 1'b0)
        else $error("status pin driven high");
endmodule

/* verif/lics_pack.sv */
// Battery pack, thermistor network and status pull-up seen by the sequencer
`timescale 1ns/100ps
module lics_pack (
    // Pack and host controls
    input  wire logic pack_in_i,
    input  wire logic therm_fixed_i,
    input  wire logic ts_pull_i,
    // Status pin from the sequencer
    input  wire logic chg_status_i,
    input  wire logic chg_status_oe_i,
    // Comparator views
    output logic      ts_high_o,
    output logic      bat_present_o,
    output logic      chg_pin_o
);
    // Removed pack floats the input high unless a fixed resistor holds it
    assign ts_high_o     = ts_pull_i | (~pack_in_i & ~therm_fixed_i);
    assign bat_present_o = pack_in_i;
    // Pull-up: released pin reads high, never the last driven level
    assign chg_pin_o     = chg_status_oe_i ? chg_status_i : 1'b1;
endmodule

/* verif/li_ion_charge_sequencer_tb.sv */
// Self-checking bench for the charge sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module li_ion_charge_sequencer_tb;
    import lics_pkg::*;
    localparam int CYC_MAX = 90000;
    localparam int DWAIT   = int'(DET_CYC) + 8;
    typedef struct { logic low, fault, lim, en, det; } lics_row_s;
    logic sys_clk_i = 0, srst_i = 1, taper_i = 0, above_rch_i = 0, ts_low_i = 0, ts_fault_i = 0;
    logic thermal_reg_i = 0, input_voltage_power_management_i = 0, usb_ilim_i = 0, pack_in = 1, therm_fixed = 0;
    logic ts_pull = 0, ts_high_w, bat_present_w, chg_pin_w, charge_en_o, precharge_o, detect_o;
    logic term_boost_o, disable_mode_o, chg_status_o, chg_status_oe_o;
    lics_state_e state_o;
    int fails = 0, n_checks = 0, cyc = 0;
    lics_row_s rows [3] = '{'{1, 0, 0, 0, 0}, '{0, 1, 0, 0, 0}, '{0, 0, 1, 1, 0}};

    lics_seq i_lics_seq (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .taper_i(taper_i),
        .above_rch_i(above_rch_i), .ts_high_i(ts_high_w), .ts_low_i(ts_low_i),
        .ts_fault_i(ts_fault_i), .thermal_reg_i(thermal_reg_i), .input_voltage_power_management_i(input_voltage_power_management_i),
        .usb_ilim_i(usb_ilim_i), .bat_present_i(bat_present_w), .charge_en_o(charge_en_o),
        .precharge_o(precharge_o), .detect_o(detect_o), .term_boost_o(term_boost_o),
        .disable_mode_o(disable_mode_o), .state_o(state_o), .chg_status_o(chg_status_o),
        .chg_status_oe_o(chg_status_oe_o));
    lics_pack i_lics_pack (.pack_in_i(pack_in), .therm_fixed_i(therm_fixed), .ts_pull_i(ts_pull),
        .chg_status_i(chg_status_o), .chg_status_oe_i(chg_status_oe_o), .ts_high_o(ts_high_w),
        .bat_present_o(bat_present_w), .chg_pin_o(chg_pin_w));

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ceiling sits above the three detection windows the run needs
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == CYC_MAX) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        step(20);
        `CHK("reset state", LICS_IDLE, state_o)
        srst_i = 0;
        step(5);
        `CHK("first state", LICS_PRE, state_o)
        `CHK("first pin", 1'b0, chg_pin_w)
        `CHK("precharge", 1'b1, precharge_o)
        `CHK("boost", 1'b1, term_boost_o)
        foreach (rows[i]) begin
            {ts_low_i, ts_fault_i} = {rows[i].low, rows[i].fault};
            {thermal_reg_i, input_voltage_power_management_i, usb_ilim_i} = {3{rows[i].lim}};
            step(5);
            `CHK("row charge", rows[i].en, charge_en_o)
            `CHK("row detect", rows[i].det, detect_o)
            {ts_low_i, ts_fault_i, thermal_reg_i, input_voltage_power_management_i, usb_ilim_i} = '0;
            step(5);
            `CHK("row restart", LICS_PRE, state_o)
            `CHK("row pin", 1'b0, chg_pin_w)
        end
        // Pulled-up thermistor input with the battery still fitted
        ts_pull = 1;
        step(5);
        `CHK("termination_timer_disable_mode entry", 1'b1, disable_mode_o)
        `CHK("entry detect", LICS_DET, state_o)
        `CHK("entry boost", 1'b0, term_boost_o)
        `CHK("detect rail", 1'b1, charge_en_o)
        step(DWAIT);
        `CHK("termination_timer_disable_mode profile", LICS_PRE, state_o)
        `CHK("termination_timer_disable_mode pin held", 1'b0, chg_pin_w)
        {taper_i, above_rch_i} = 2'h3;
        step(5);
        `CHK("taper pin", 1'b1, chg_pin_w)
        `CHK("taper output on", 1'b1, charge_en_o)
        `CHK("no term", 1'b0, state_o == LICS_DONE)
        {taper_i, above_rch_i, ts_pull} = 3'h0;
        step(5);
        `CHK("termination_timer_disable_mode exit", 1'b0, disable_mode_o)
        `CHK("exit detect", LICS_DET, state_o)
        step(DWAIT);
        `CHK("new cycle", LICS_PRE, state_o)
        `CHK("new cycle pin", 1'b0, chg_pin_w)
        // Power-up above threshold, pack gone, thermistor held active
        {srst_i, above_rch_i, therm_fixed, pack_in} = 4'he;
        step(20);
        `CHK("reset oe", 1'b0, chg_status_oe_o)
        srst_i = 0;
        step(5);
        `CHK("power-up detect", LICS_DET, state_o)
        step(DWAIT);
        `CHK("repeat detect", LICS_DET, state_o)
        `CHK("missing pin", 1'b1, chg_pin_w)
        tally_and_finish();
    end
endmodule

bind lics_seq lics_seq_assertions i_lics_seq_assertions (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .taper_i(taper_i), .above_rch_i(above_rch_i), .ts_high_i(ts_high_i), .ts_low_i(ts_low_i),
    .ts_fault_i(ts_fault_i), .thermal_reg_i(thermal_reg_i), .input_voltage_power_management_i(input_voltage_power_management_i),
    .usb_ilim_i(usb_ilim_i), .bat_present_i(bat_present_i), .charge_en_o(charge_en_o),
    .precharge_o(precharge_o), .detect_o(detect_o), .term_boost_o(term_boost_o),
    .disable_mode_o(disable_mode_o), .chg_status_o(chg_status_o),
    .chg_status_oe_o(chg_status_oe_o), .state_o(state_o));
